/* sbt_tap.sv */
// boundary-scan test access port with its pad-side control
// Summary of operation
// - sample tms, tdi on rising tck only
// - undriven tms and tdi read high
// - tdi enters msb, tdo from lsb
// - tdo changes on every falling tck, driven in shift only
// - five high tms edges reach reset
// - power-up reset leaves tdo floating
// - instruction selects exactly one data register
// - three-bit ir, idcode after reset
// - capture-ir loads 01 in low bits
// - bypass bit cleared, one stage delay
// - boundary capture pins, shift in shift-dr
// - idcode captures fixed 32-bit code
// - new instruction acts at update-ir
// - sample-z shifts boundary, floats output bus
// - sample/preload snapshots pins, pins unchanged
// - preload shifts in, update latches pattern
// - bypass routes tdi to tdo
// - extest drives preloaded cells onto outputs
// - control cell enables drivers when one
// - control cell preset one in reset
// - id bit zero reads one
`timescale 1ns/1ns
`include "sbt_params.svh"

////////////////////////////////////////////////////////////////////////////////
module sbt_sync
    import sbt_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            sbt_sync_bit_t st;
            sbt_sync_bit_t next_st;
            // a change is taken only once stages two and three agree
            always_comb begin
                next_st.s1  = i_d[g];
                next_st.s2  = st.s1;
                next_st.s3  = st.s2;
                next_st.val = (st.s2 == st.s3) ? st.s3 : st.val;
                if (!i_rst_n) begin
                    next_st = '0;
                end
            end
            always_ff @(posedge i_clk) begin
                st <= next_st;
            end
            assign o_q[g] = st.val;
        end
    endgenerate
endmodule // sbt_sync

////////////////////////////////////////////////////////////////////////////////
module sbt_tap
    import sbt_pkg::*;
#(
    // arbitrary neutral maker code
    parameter logic [10:0] VENDOR_ID = 11'h155
) (
    input  wire logic                 I_CLK,
    input  wire logic                 I_RESETN,
    input  wire logic                 I_TCK,
    input  wire logic                 I_TMS,
    input  wire logic                 I_TMS_EN,
    input  wire logic                 I_TDI,
    input  wire logic                 I_TDI_EN,
    output logic                      O_TDO,
    output logic                      O_TDO_OE,
    input  wire logic [`SBT_PIN_W-1:0] I_PINS,
    input  wire sbt_dq_t              I_CORE,
    output sbt_dq_t                   O_DQ
);
    logic                    rst_tck_n;
    logic [`SBT_PIN_W-1:0]   pins;
    logic                    tms;
    logic                    tdi;
    logic                    sel_bnd;
    logic                    sel_id;
    logic                    sel_lsb;
    logic                    shifting;
    logic [`SBT_ID_W-1:0]    id_code;
    sbt_tap_st_t             st;
    sbt_tap_st_t             next_st;
    logic                    tdo;
    logic                    tdo_oe;
    sbt_cross_t              xs;
    sbt_dq_t                 dq;
    sbt_dq_t                 next_dq;

    ////////////////////////////////////////////////////////////////////////////
    // power-up reset reaches the tck side only while tck runs
    // every stage is cleared while the raw level is low, so no unknown survives the first tck edge
    sbt_sync #(.W(1)) u_rst_sync (
        .i_clk   (I_TCK),
        .i_rst_n (I_RESETN),
        .i_d     (I_RESETN),
        .o_q     (rst_tck_n)
    );

    // ring pins come from the memory clock side
    sbt_sync #(.W(`SBT_PIN_W)) u_pin_sync (
        .i_clk   (I_TCK),
        .i_rst_n (rst_tck_n),
        .i_d     (I_PINS),
        .o_q     (pins)
    );

    assign tms = I_TMS_EN ? I_TMS : 1'b1;
    assign tdi = I_TDI_EN ? I_TDI : 1'b1;

    assign id_code = {`SBT_ID_REV, `SBT_ID_DEPTH, `SBT_ID_TYPE, `SBT_ID_WIDTH,
                      VENDOR_ID, `SBT_ID_PRESENT};

    assign sel_bnd = (st.ir == `SBT_OP_EXTEST) || (st.ir == `SBT_OP_SAMPLEZ) ||
                     (st.ir == `SBT_OP_SAMPLE);
    assign sel_id  = (st.ir == `SBT_OP_IDCODE);

    ////////////////////////////////////////////////////////////////////////////
    // tap state and registers, all on rising tck
    always_comb begin
        next_st = st;
        // tms high always heads to reset
        case (st.state)
            ST_TLR:    next_st.state = tms ? ST_TLR    : ST_RTI;
            ST_RTI:    next_st.state = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: next_st.state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_st.state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_st.state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_st.state = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_st.state = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_st.state = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_st.state = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: next_st.state = tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: next_st.state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_st.state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_st.state = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_st.state = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_st.state = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_st.state = tms ? ST_SEL_DR : ST_RTI;
            default:   next_st.state = ST_TLR;
        endcase

        case (st.state)
            ST_CAP_IR: next_st.ir_sh = `SBT_IR_CAPTURE;
            ST_SH_IR:  next_st.ir_sh = {tdi, st.ir_sh[`SBT_IR_W-1:1]};
            ST_UPD_IR: next_st.ir = st.ir_sh;
            ST_CAP_DR: begin
                if (sel_bnd) begin
                    next_st.bsr_sh = {st.bsr_upd[`SBT_CTRL_CELL], pins};
                end else if (sel_id) begin
                    next_st.idr = id_code;
                end else begin
                    next_st.bypass = 1'b0;
                end
            end
            ST_SH_DR: begin
                // capture out while preload comes in
                if (sel_bnd) begin
                    next_st.bsr_sh = {tdi, st.bsr_sh[`SBT_BSR_LEN-1:1]};
                end else if (sel_id) begin
                    next_st.idr = {tdi, st.idr[`SBT_ID_W-1:1]};
                end else begin
                    next_st.bypass = tdi;
                end
            end
            ST_UPD_DR: if (sel_bnd) next_st.bsr_upd = st.bsr_sh;
            default: ;
        endcase

        // set on the entering edge, so a stopped tck still leaves idcode active
        // idcode in reset
        if (next_st.state == ST_TLR) begin
            next_st.ir = `SBT_OP_IDCODE;
            next_st.bsr_upd[`SBT_CTRL_CELL] = 1'b1;
        end

        if (!rst_tck_n) begin
            next_st       = '0;
            next_st.state = ST_TLR;
            next_st.ir    = `SBT_OP_IDCODE;
            next_st.bsr_upd[`SBT_CTRL_CELL] = 1'b1;
        end

        // registered so the crossing sees no glitches, reset values included
        next_st.xo.extest  = (next_st.ir == `SBT_OP_EXTEST);
        next_st.xo.samplez = (next_st.ir == `SBT_OP_SAMPLEZ);
        next_st.xo.ctrl    = next_st.bsr_upd[`SBT_CTRL_CELL];
        next_st.xo.data    = next_st.bsr_upd[`SBT_DQ_W-1:0];
    end

    // tms and tdi taken on rising tck
    always_ff @(posedge I_TCK) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign shifting = (st.state == ST_SH_DR) || (st.state == ST_SH_IR);

    always_comb begin
        if (st.state == ST_SH_IR) begin
            sel_lsb = st.ir_sh[0];
        end else if (sel_bnd) begin
            sel_lsb = st.bsr_sh[0];
        end else if (sel_id) begin
            sel_lsb = st.idr[0];
        end else begin
            sel_lsb = st.bypass;
        end
    end

    always_ff @(negedge I_TCK) begin
        if (!rst_tck_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= sel_lsb;
            tdo_oe <= shifting;
        end
    end

    assign O_TDO    = tdo;
    assign O_TDO_OE = tdo_oe;

    ////////////////////////////////////////////////////////////////////////////
    // quasi-static controls: values only settle between tap updates
    sbt_sync #(.W($bits(sbt_cross_t))) u_x_sync (
        .i_clk   (I_CLK),
        .i_rst_n (I_RESETN),
        .i_d     (st.xo),
        .o_q     (xs)
    );

    always_comb begin
        next_dq = I_CORE;
        if (xs.extest) begin
            next_dq.data = xs.data;
            next_dq.oe   = xs.ctrl;
        end
        if (xs.samplez) begin
            next_dq.oe = 1'b0;
        end
        if (!I_RESETN) begin
            next_dq = '0;
        end
    end

    always_ff @(posedge I_CLK) begin
        dq <= next_dq;
    end

    assign O_DQ = dq;

    ////////////////////////////////////////////////////////////////////////////
    chk_tms_reset: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        tms [*5] |=> st.state == ST_TLR && st.ir == `SBT_OP_IDCODE)
        else $error("five high tms edges did not reach reset");

    chk_ir_idcode: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_TLR |=> st.ir == `SBT_OP_IDCODE)
        else $error("reset did not load idcode");

    chk_capture_ir: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_CAP_IR |=> st.ir_sh[1:0] == 2'h1)
        else $error("capture-ir pattern wrong");

    chk_ir_hold: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state != ST_UPD_IR && st.state != ST_TLR && !(st.state == ST_SEL_IR && tms)
            |=> $stable(st.ir))
        else $error("instruction changed outside update-ir");

    chk_bypass_clear: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_CAP_DR && !sel_bnd && !sel_id |=> !st.bypass)
        else $error("bypass not cleared on capture");

    chk_id_capture: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_CAP_DR && sel_id |=> st.idr == id_code && st.idr[0])
        else $error("identification code not captured");

    chk_bsr_msb: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_SH_DR && sel_bnd |=> st.bsr_sh[`SBT_BSR_LEN-1] == $past(tdi))
        else $error("boundary shift did not take tdi at msb");

    chk_bypass_path: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_SH_DR && !sel_bnd && !sel_id |=> st.bypass == $past(tdi))
        else $error("bypass stage did not take tdi");

    chk_update_latch: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_UPD_DR && sel_bnd |=> st.bsr_upd == $past(st.bsr_sh))
        else $error("update did not latch the boundary pattern");

    chk_tdo_drive: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        ##1 tdo_oe == shifting)
        else $error("tdo enable outside shift states");

    chk_tdo_lsb: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        ##1 tdo_oe |-> tdo == sel_lsb)
        else $error("tdo not fed from selected lsb");

    chk_ctrl_preset: assert property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_TLR |=> st.bsr_upd[`SBT_CTRL_CELL])
        else $error("control cell not preset");

    chk_samplez_float: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        xs.samplez |=> !O_DQ.oe)
        else $error("output bus driven under sample-z");

    chk_extest_drive: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        xs.extest && !xs.samplez |=> O_DQ.data == $past(xs.data) && O_DQ.oe == $past(xs.ctrl))
        else $error("extest did not drive preloaded cells");

    cov_ir_shift: cover property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_SH_IR ##1 st.state == ST_EX1_IR ##1 st.state == ST_UPD_IR);
    cov_bypass_shift: cover property (@(posedge I_TCK) disable iff (!rst_tck_n)
        st.state == ST_SH_DR && st.ir == `SBT_OP_BYPASS);
    cov_extest: cover property (@(posedge I_CLK) disable iff (!I_RESETN)
        xs.extest && O_DQ.oe);
endmodule // sbt_tap

/* sbt_params.svh */
// constants of the sram boundary-scan test port
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH
`define SBT_IR_W        3
`define SBT_ID_W        32
`define SBT_BSR_LEN     89
`define SBT_PIN_W       88
`define SBT_DQ_W        36
`define SBT_CTRL_CELL   88
`define SBT_OP_EXTEST   3'h0
`define SBT_OP_IDCODE   3'h1
`define SBT_OP_SAMPLEZ  3'h2
`define SBT_OP_SAMPLE   3'h4
`define SBT_OP_BYPASS   3'h7
`define SBT_IR_CAPTURE  3'h1
`define SBT_ID_REV      3'h0
`define SBT_ID_DEPTH    5'h0B
`define SBT_ID_TYPE     6'h08
`define SBT_ID_WIDTH    6'h27
`define SBT_ID_PRESENT  1'h1
`define SBT_TMS_RESET_N 5
`endif

/* sbt_pkg.sv */
// types of the sram boundary-scan test port
`include "sbt_params.svh"
package sbt_pkg;
    typedef enum logic [15:0] {
        ST_TLR    = 16'h0001,
        ST_RTI    = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR  = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR  = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sbt_state_t;

    typedef struct packed {
        logic [`SBT_DQ_W-1:0] data;
        logic                 oe;
    } sbt_dq_t;

    typedef struct packed {
        logic                 extest;
        logic                 samplez;
        logic                 ctrl;
        logic [`SBT_DQ_W-1:0] data;
    } sbt_cross_t;

    typedef struct packed {
        sbt_state_t              state;
        logic [`SBT_IR_W-1:0]    ir;
        logic [`SBT_IR_W-1:0]    ir_sh;
        logic                    bypass;
        logic [`SBT_ID_W-1:0]    idr;
        logic [`SBT_BSR_LEN-1:0] bsr_sh;
        logic [`SBT_BSR_LEN-1:0] bsr_upd;
        sbt_cross_t              xo;
    } sbt_tap_st_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic val;
    } sbt_sync_bit_t;
endpackage

/* sbt_jtag_host.sv */
// board test controller model that drives the scan chain of the test port
`timescale 1ns/1ns

module sbt_jtag_host (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tms_en,
    output logic      o_tdi,
    output logic      o_tdi_en,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);
    // tck idles low; released lines fall back on the pad pull-ups
    initial begin
        o_tck    = 1'b0;
        o_tms    = 1'b0;
        o_tdi    = 1'b0;
        o_tms_en = 1'b0;
        o_tdi_en = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one tck period; tdo sampled just before the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
        o_tms_en = 1'b1;
        o_tdi_en = 1'b1;
        o_tms    = tms;
        o_tdi    = tdi;
        #14;
        // a floating tdo must not look like a stale good bit
        tdo      = i_tdo_oe ? i_tdo : ~i_tdo;
        oe       = i_tdo_oe;
        #1 o_tck = 1'b1;
        #15 o_tck = 1'b0;
    endtask

    task automatic idle(input int n);
        o_tms_en = 1'b0;
        o_tdi_en = 1'b0;
        repeat (n) begin
            #15 o_tck = 1'b1;
            #15 o_tck = 1'b0;
        end
    endtask

    // standard walk: capture, shift lsb first, update, idle
    task automatic scan(input logic ir, input int n, input logic [88:0] din,
                        output logic [88:0] dout, output logic oe_all);
        logic b;
        logic oe;
        dout   = '0;
        oe_all = 1'b1;
        step(1'b0, 1'b1, b, oe);
        step(1'b1, 1'b1, b, oe);
        if (ir) begin
            step(1'b1, 1'b1, b, oe);
        end
        step(1'b0, 1'b1, b, oe);
        step(1'b0, 1'b1, b, oe);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b, oe);
            dout[i] = b;
            oe_all  = oe_all & oe;
        end
        step(1'b1, 1'b1, b, oe);
        step(1'b0, 1'b1, b, oe);
        o_tms_en = 1'b0;
        o_tdi_en = 1'b0;
    endtask
endmodule // sbt_jtag_host

/* tb.sv */
// self-checking testbench of the boundary-scan test port
`timescale 1ns/1ns
`include "sbt_params.svh"

module tb
    import sbt_pkg::*;
;
    // arbitrary maker code
    localparam logic [10:0] VID = 11'h2A5;
    localparam logic [31:0] ID  = {`SBT_ID_REV, `SBT_ID_DEPTH, `SBT_ID_TYPE,
                                   `SBT_ID_WIDTH, VID, `SBT_ID_PRESENT};
    localparam logic [87:0] PINS = 88'hC3A5_9F01_7E2D_4B86_1234_5A;
    localparam logic [88:0] PRE  = {1'b1, 52'h0, 36'h5_A5A5_A5A5};

    logic            I_CLK = 1'b0;
    logic            I_RESETN = 1'b0;
    logic [87:0]     pins = '0;
    sbt_dq_t         core = '0;
    sbt_dq_t         dq;
    logic            tck, tms, tms_en, tdi, tdi_en, tdo, tdo_oe;
    logic [88:0]     d;
    int              bad_count = 0;
    int              checks_done = 0;

    always #20 I_CLK = ~I_CLK;

    sbt_tap #(.VENDOR_ID(VID)) u_dut (
        .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_TCK(tck), .I_TMS(tms),
        .I_TMS_EN(tms_en), .I_TDI(tdi), .I_TDI_EN(tdi_en), .O_TDO(tdo),
        .O_TDO_OE(tdo_oe), .I_PINS(pins), .I_CORE(core), .O_DQ(dq)
    );

    sbt_jtag_host u_host (
        .o_tck(tck), .o_tms(tms), .o_tms_en(tms_en), .o_tdi(tdi),
        .o_tdi_en(tdi_en), .i_tdo(tdo), .i_tdo_oe(tdo_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // crossing into the pad domain takes several memory clocks
    task automatic settle();
        #5;
        check(tdo_oe, 1'b0);
        repeat (8) @(negedge I_CLK);
    endtask

    task automatic ir_load(input logic [2:0] op);
        logic oe;
        u_host.scan(1'b1, 3, {86'h0, op}, d, oe);
        check(d[2:0], `SBT_IR_CAPTURE);
        check(oe, 1'b1);
        settle();
    endtask

    task automatic dr(input int n, input logic [88:0] din);
        logic oe;
        u_host.scan(1'b0, n, din, d, oe);
        check(oe, 1'b1);
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_idcode();
        check(dq, core);
        dr(32, 89'h0);
        check(d[31:0], ID);
    endtask

    task automatic t_bypass();
        ir_load(`SBT_OP_BYPASS);
        dr(8, 89'hA5);
        // one stage of delay behind a captured zero
        check(d[7:0], 8'h4A);
    endtask

    // pins held still across the capture
    task automatic t_sample();
        @(negedge I_CLK);
        pins = PINS;
        core = '{data: 36'h9_8765_4321, oe: 1'b1};
        repeat (8) @(negedge I_CLK);
        ir_load(`SBT_OP_SAMPLE);
        dr(89, PRE);
        check(d[87:0], PINS);
        check(d[88], 1'b1);
        check(dq, core);
    endtask

    task automatic t_extest();
        ir_load(`SBT_OP_EXTEST);
        check(dq, {PRE[35:0], 1'b1});
        dr(89, 89'h0);
        check(d[87:0], PINS);
        check(d[88], 1'b1);
        check(dq, {36'h0, 1'b0});
    endtask

    task automatic t_samplez();
        ir_load(`SBT_OP_SAMPLEZ);
        check(dq.oe, 1'b0);
        check(dq.data, core.data);
        dr(89, 89'h0);
        check(d[87:0], PINS);
    endtask

    task automatic t_tms_reset();
        u_host.idle(5);
        settle();
        check(dq, core);
        dr(32, 89'h0);
        check(d[31:0], ID);
        ir_load(`SBT_OP_EXTEST);
        check(dq, {36'h0, 1'b1});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        fork
            repeat (8) @(posedge I_CLK);
            u_host.idle(10);
        join
        @(negedge I_CLK);
        I_RESETN = 1'b1;
        u_host.idle(6);
        settle();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_samplez();
        t_tms_reset();
        complete_run();
    end

    // whole run needs well under 100 us of scan traffic
    initial begin
        #300000;
        bad_count++;
        complete_run();
    end
endmodule // tb
